// ---- rtl/tad_attribute_decoder.v ----
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Overview of operation
// - Twist code toggles alternative code table
// - Alternative-default language chosen per east/west value
// - Codes 80H-9FH render as OSD symbols
// - Read-only 5-bit character set identity
// - 525-line syncs drop cell bottom line
// - Control codes decoded, shown as spaces
// - Alpha colour sets foreground, mosaics off
// - Graphics colour sets foreground, mosaics on
// - Background codes set colour at position
// - Flash blinks characters until steady code
// - Conceal shows spaces until colour code
// - Hold shows last graphics character received since the hold code
// - Box starts after two start codes
// - Size codes; double height blanks next row
// - Right-half cell discarded, controls still act
// - Video select from normal or flash set
// - Boxes change mode only when row-enabled
// - Contrast reduction from selected control set
// - Picture, text, background bits select mode
// - Meshing shows video on alternate background pixels
// - Transparency overrides black mesh; shadow combines
// - Mesh and transparency only in text mode
// - Shadow adds pixel below-right of foreground
// - Page flags select newsflash control set
`include "tad_regs.vh"
module tad_attribute_decoder #(
    parameter [4:0] CHARSET_VERSION = 5'h15  // Arbitrary identity value
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Character stream from page memory
    input  wire        row_start,
    input  wire [4:0]  row_num,
    input  wire        char_valid,
    input  wire [7:0]  char_code,
    input  wire [7:0]  page_attr_c5,
    input  wire [2:0]  page_lang,
    input  wire        flash_phase,
    // Cell descriptor to glyph generator
    output reg         cell_valid,
    output reg  [7:0]  cell_code,
    output reg         cell_alt_table,
    output reg         cell_osd_symbol,
    output reg         cell_mosaic,
    output reg         cell_separated,
    output reg  [2:0]  cell_fg,
    output reg  [2:0]  cell_bg,
    output reg  [1:0]  cell_size,
    output reg         cell_right_half,
    output reg         cell_box,
    // Line and pixel path
    input  wire        sync_525,
    input  wire [3:0]  cell_line,
    input  wire        pix_valid,
    input  wire        pix_fg,
    input  wire        pix_shadow_src,
    input  wire        pix_odd,
    input  wire        pix_box,
    input  wire        pix_osd_box,
    input  wire        pix_bg_black,
    input  wire        pix_text_area,
    output reg         line_skip,
    output reg         video_source_select_out,
    output reg         contrast_reduce_out_n
);
    // Control decode used by stream and hold logic
    function is_ctrl;
        input [7:0] c;
        begin
            is_ctrl = (c[7:5] == 3'h0) || (c[7:3] == 5'h16) || (c[7:2] == 6'h2F);
        end
    endfunction
    // Software registers
    reg [7:0]  normal_page_mode_ctrl;   // Mode set for normal pages
    reg [7:0]  flash_page_mode_ctrl;    // Mode set for newsflash/subtitle pages
    reg [2:0]  box_row_enable_ctrl;     // Box enables per row group
    reg [15:0] enhancement_ctrl;        // Shadow, mesh, transparency, languages
    reg        show_concealed_enable;   // Display feature: show_concealed_enable
    wire [4:0] charset_version_code = CHARSET_VERSION;
    // Serial attribute state
    reg [2:0] fg;          // Foreground colour
    reg [2:0] bg;          // Background colour
    reg       mosaic;      // Graphics mode
    reg       sep;         // Separated mosaics
    reg       flash;       // Flashing
    reg       conceal;     // Concealed
    reg       hold;        // Hold graphics
    reg [7:0] held_code;   // Last graphics character
    reg       held_sep;    // Shape style of held character
    reg [1:0] size;        // Character size
    reg       box;         // Inside teletext box
    reg       box_pend;    // Previous code was a start box
    reg       twist;       // Code table toggled
    reg       right_half;  // Next cell is right half of wide character
    reg       dh_row;      // Double height seen on this row
    reg       dh_prev;     // Previous row carried double height
    // APB decode; registers sit on aligned words up to the identity slot
    wire apb_acc = psel && penable && pready;
    wire apb_wr  = apb_acc && pwrite;
    wire mapped  = (paddr[1:0] == 2'h0) && (paddr <= `TAD_OFF_IDENT);
    reg [31:0] next_prdata;
    // Read mux
    always @*
    begin
        case (paddr)
            `TAD_OFF_NORMAL: next_prdata = {24'h00_0000, normal_page_mode_ctrl};
            `TAD_OFF_FLASH:  next_prdata = {24'h00_0000, flash_page_mode_ctrl};
            `TAD_OFF_BOXROW: next_prdata = {29'h0000_0000, box_row_enable_ctrl};
            `TAD_OFF_ENH:    next_prdata = {16'h0000, enhancement_ctrl};
            `TAD_OFF_FEAT:   next_prdata = {31'h0000_0000, show_concealed_enable};
            `TAD_OFF_IDENT:  next_prdata = {22'h00_0000, dh_row, box, 3'h0, charset_version_code};
            default:         next_prdata = 32'h0000_0000;
        endcase
    end
    // APB slave: one wait-free access phase, answer registered
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            prdata                <= 32'h0000_0000;
            normal_page_mode_ctrl <= `TAD_RST_MODE;
            flash_page_mode_ctrl  <= `TAD_RST_MODE;
            box_row_enable_ctrl   <= `TAD_RST_BOXROW;
            enhancement_ctrl      <= `TAD_RST_ENH;
            show_concealed_enable <= `TAD_RST_FEAT;
        end
        else
        begin
            // Ready during the cycle after setup
            pready  <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
            if (apb_wr)
            begin
                case (paddr)
                    `TAD_OFF_NORMAL: normal_page_mode_ctrl <= pwdata[7:0];
                    `TAD_OFF_FLASH:  flash_page_mode_ctrl  <= pwdata[7:0];
                    `TAD_OFF_BOXROW: box_row_enable_ctrl   <= pwdata[2:0];
                    `TAD_OFF_ENH:    enhancement_ctrl      <= pwdata[15:0];
                    `TAD_OFF_FEAT:   show_concealed_enable <= pwdata[`TAD_FT_SHOW_CONCEALED_ENABLE];
                    default:         ;
                endcase
            end
        end
    end
    // Character classification
    wire       ctrl      = is_ctrl(char_code);
    wire       mos_col   = !char_code[7] && char_code[5];               // Columns 2, 3, 6, 7
    wire       alpha_col = (char_code[7:3] == 5'h00) && !char_code[3];  // 00H-07H
    wire       gfx_col   = (char_code[7:3] == 5'h02);                   // 10H-17H
    wire       bg_upper  = (char_code[7:3] == 5'h16);                   // B0H-B7H
    wire       no_dh     = (row_num >= `TAD_ROW_LAST_DH + 5'h01);       // Rows 23, 24
    wire [2:0] lang_alt  = enhancement_ctrl[`TAD_EN_EASTWEST]
                         ? enhancement_ctrl[`TAD_EN_LANG1_LO +: 3] : enhancement_ctrl[`TAD_EN_LANG0_LO +: 3];
    wire       alt_dflt  = (page_lang == lang_alt);
    // Next-state values for attributes
    reg [2:0] next_fg, next_bg;
    reg [1:0] next_size;
    reg       next_mosaic, next_sep, next_flash, next_conceal, next_hold, next_box, next_twist;
    // Control character effects
    always @*
    begin
        // Attributes hold unless a control code moves them
        {next_fg, next_bg, next_mosaic, next_sep, next_flash} = {fg, bg, mosaic, sep, flash};
        {next_conceal, next_hold, next_size, next_box, next_twist} = {conceal, hold, size, box, twist};
        if (alpha_col)
        begin
            next_fg      = char_code[2:0];
            next_mosaic  = 1'b0;
            next_conceal = 1'b0;
        end
        else if (gfx_col)
        begin
            next_fg      = char_code[2:0];
            next_mosaic  = 1'b1;
            next_conceal = 1'b0;
        end
        else if (bg_upper)
            next_bg = char_code[2:0];
        else
        begin
            case (char_code)
                `TAD_C_FLASH:    next_flash   = 1'b1;
                `TAD_C_STEADY:   next_flash   = 1'b0;
                `TAD_C_ENDBOX:   next_box     = 1'b0;
                `TAD_C_STARTBOX: next_box     = box | box_pend;
                `TAD_C_NORMAL:   next_size    = `TAD_SZ_NORMAL;
                `TAD_C_DBLHGT:   next_size    = no_dh ? `TAD_SZ_NORMAL : `TAD_SZ_DH;
                `TAD_C_DBLWID:   next_size    = `TAD_SZ_DW;
                `TAD_C_DBLSIZE:  next_size    = no_dh ? `TAD_SZ_DW : `TAD_SZ_DS;
                `TAD_C_CONCEAL:  next_conceal = 1'b1;
                `TAD_C_CONTIG:   next_sep     = 1'b0;
                `TAD_C_SEPAR:    next_sep     = 1'b1;
                `TAD_C_TWIST:    next_twist   = !twist;
                `TAD_C_BLACKBG:  next_bg      = `TAD_COL_BLACK;
                `TAD_C_NEWBG:    next_bg      = fg;
                `TAD_C_HOLD:     next_hold    = 1'b1;
                `TAD_C_RELEASE:  next_hold    = 1'b0;
                default:         ;
            endcase
        end
    end
    // Displayed code for this cell
    reg [7:0] next_code;
    reg       next_cmos, next_csep;
    always @*
    begin
        next_code = char_code;
        next_cmos = mosaic && mos_col;
        next_csep = sep;
        if (ctrl)
        begin
            next_code = hold ? held_code : `TAD_C_SPACE;
            next_cmos = hold && mosaic;
            next_csep = held_sep;
        end
        else if ((conceal && !show_concealed_enable) || (flash && flash_phase) || dh_prev)
        begin
            next_code = `TAD_C_SPACE;
            next_cmos = 1'b0;
        end
    end
    // Serial attribute and cell pipeline
    always @(posedge mclk)
    begin
        if (!rstn || row_start)
        begin
            // Row start defaults
            fg         <= `TAD_COL_WHITE;
            bg         <= `TAD_COL_BLACK;
            held_code  <= `TAD_C_SPACE;
            size       <= `TAD_SZ_NORMAL;
            // Steady, revealed, contiguous, released, outside box, first table
            {mosaic, sep, flash, conceal, hold, held_sep} <= 6'h00;
            {box, box_pend, twist, right_half, dh_row}    <= 5'h00;
        end
        else if (char_valid)
        begin
            {fg, bg, mosaic, sep, flash} <= {next_fg, next_bg, next_mosaic, next_sep, next_flash};
            {conceal, hold, size, box, twist} <= {next_conceal, next_hold, next_size, next_box, next_twist};
            box_pend   <= (char_code == `TAD_C_STARTBOX);
            // Wide characters swallow the following cell
            right_half <= !right_half && size[1] && !ctrl;
            if (!right_half && !ctrl && size[0])
                dh_row <= 1'b1;
            if (char_code == `TAD_C_HOLD)
                held_code <= `TAD_C_SPACE;
            else if (!right_half && !ctrl && mosaic && mos_col)
            begin
                held_code <= char_code;
                held_sep  <= sep;
            end
        end
    end
    // Previous-row double height flag
    always @(posedge mclk)
    begin
        if (!rstn)
            dh_prev <= 1'b0;
        else if (row_start)
            dh_prev <= dh_row && !dh_prev;
    end
    // Cell descriptor outputs
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            cell_code       <= `TAD_C_SPACE;
            cell_fg         <= `TAD_COL_WHITE;
            cell_bg         <= `TAD_COL_BLACK;
            cell_size       <= `TAD_SZ_NORMAL;
            {cell_valid, cell_alt_table, cell_osd_symbol, cell_mosaic} <= 4'h0;
            {cell_separated, cell_right_half, cell_box}                 <= 3'h0;
        end
        else
        begin
            cell_valid      <= char_valid && !row_start;
            cell_code       <= next_code;
            cell_alt_table  <= alt_dflt ^ twist;
            cell_osd_symbol <= !ctrl && (char_code[7:5] == 3'h4);
            cell_mosaic     <= next_cmos;
            cell_separated  <= next_csep;
            cell_fg         <= fg;
            cell_bg         <= next_bg;  // every background code acts at its own cell
            cell_size       <= size;
            cell_right_half <= right_half;
            cell_box        <= box || (char_code == `TAD_C_STARTBOX && box_pend);
        end
    end
    // Display mode selection
    wire       flash_page = page_attr_c5[`TAD_PA_NEWSFLASH] || page_attr_c5[`TAD_PA_SUBTITLE];
    wire [7:0] mode       = flash_page ? flash_page_mode_ctrl : normal_page_mode_ctrl;
    wire       box_en     = (row_num == 5'h00) ? box_row_enable_ctrl[`TAD_BX_ROW0]
                          : (row_num == `TAD_ROW_STATUS) ? box_row_enable_ctrl[`TAD_BX_ROW24]
                          : box_row_enable_ctrl[`TAD_BX_ROWMID];
    wire       in_box     = pix_box && box_en;
    wire       pic        = in_box ? mode[`TAD_MD_PIC_IN] : mode[`TAD_MD_PIC_OUT];
    wire       txt        = in_box ? mode[`TAD_MD_TXT_IN] : mode[`TAD_MD_TXT_OUT];
    wire       bkg        = in_box ? mode[`TAD_MD_BKG_IN] : mode[`TAD_MD_BKG_OUT];
    wire       contrast_reduce_out        = in_box ? mode[`TAD_MD_COR_IN] : mode[`TAD_MD_COR_OUT];
    wire       txt_mode   = (txt && bkg) || pix_osd_box;
    wire       fg_pix     = pix_fg || (enhancement_ctrl[`TAD_EN_SHADOW] && pix_shadow_src);
    wire       black_transparency_enable      = enhancement_ctrl[`TAD_EN_BLACK_TRANSPARENCY_ENABLE];
    wire       mesh       = pix_bg_black ? (enhancement_ctrl[`TAD_EN_BLACK_BG_MESH_ENABLE] && !black_transparency_enable)
                          : enhancement_ctrl[`TAD_EN_COLOUR_BG_MESH_ENABLE];
    reg        next_vds;
    // Video select per pixel
    always @*
    begin
        if (pix_osd_box || (pix_text_area && txt_mode))
        begin
            if (fg_pix)
                next_vds = 1'b1;
            else if (black_transparency_enable && pix_bg_black)
                next_vds = 1'b0;
            else if (mesh)
                next_vds = pix_odd;
            else
                next_vds = 1'b1;
        end
        else if (!pic)
            next_vds = 1'b1;
        else if (!txt || !pix_text_area)
            next_vds = 1'b0;
        else
            next_vds = fg_pix;
    end
    // Pixel and line outputs
    always @(posedge mclk)
    begin
        if (!rstn)
        begin
            video_source_select_out <= 1'b0;
            contrast_reduce_out_n   <= 1'b1;
            line_skip               <= 1'b0;
        end
        else
        begin
            if (pix_valid)
            begin
                video_source_select_out <= next_vds;
                contrast_reduce_out_n   <= !(contrast_reduce_out && pix_text_area);
            end
            line_skip <= sync_525 && (cell_line == `TAD_CELL_BOTTOM);
        end
    end
endmodule // tad_attribute_decoder

// ---- rtl/tad_regs.vh ----
`ifndef TAD_REGS_VH
`define TAD_REGS_VH
// Register byte offsets
`define TAD_OFF_NORMAL   8'h00
`define TAD_OFF_FLASH    8'h04
`define TAD_OFF_BOXROW   8'h08
`define TAD_OFF_ENH      8'h0C
`define TAD_OFF_FEAT     8'h10
`define TAD_OFF_IDENT    8'h14
// Display mode control fields (normal and newsflash/subtitle sets)
`define TAD_MD_PIC_OUT   0
`define TAD_MD_TXT_OUT   1
`define TAD_MD_BKG_OUT   2
`define TAD_MD_PIC_IN    3
`define TAD_MD_TXT_IN    4
`define TAD_MD_BKG_IN    5
`define TAD_MD_COR_OUT   6
`define TAD_MD_COR_IN    7
// Box row enable fields
`define TAD_BX_ROW0      0
`define TAD_BX_ROWMID    1
`define TAD_BX_ROW24     2
// Enhancement fields
`define TAD_EN_SHADOW    0
`define TAD_EN_BLACK_TRANSPARENCY_ENABLE     1
`define TAD_EN_BLACK_BG_MESH_ENABLE     2
`define TAD_EN_COLOUR_BG_MESH_ENABLE     3
`define TAD_EN_EASTWEST  4
`define TAD_EN_LANG0_LO  8
`define TAD_EN_LANG1_LO  12
// Display feature fields
`define TAD_FT_SHOW_CONCEALED_ENABLE    0
// Page attribute column 5 flags
`define TAD_PA_NEWSFLASH 2
`define TAD_PA_SUBTITLE  3
// Reset values
`define TAD_RST_MODE     8'h01
`define TAD_RST_BOXROW   3'h0
`define TAD_RST_ENH      16'h0000
`define TAD_RST_FEAT     1'b0
// Control codes
`define TAD_C_FLASH      8'h08
`define TAD_C_STEADY     8'h09
`define TAD_C_ENDBOX     8'h0A
`define TAD_C_STARTBOX   8'h0B
`define TAD_C_NORMAL     8'h0C
`define TAD_C_DBLHGT     8'h0D
`define TAD_C_DBLWID     8'h0E
`define TAD_C_DBLSIZE    8'h0F
`define TAD_C_CONCEAL    8'h18
`define TAD_C_CONTIG     8'h19
`define TAD_C_SEPAR      8'h1A
`define TAD_C_TWIST      8'h1B
`define TAD_C_BLACKBG    8'h1C
`define TAD_C_NEWBG      8'h1D
`define TAD_C_HOLD       8'h1E
`define TAD_C_RELEASE    8'h1F
`define TAD_C_SPACE      8'h20
`define TAD_COL_WHITE    3'h7
`define TAD_COL_BLACK    3'h0
// Size codes
`define TAD_SZ_NORMAL    2'h0
`define TAD_SZ_DH        2'h1
`define TAD_SZ_DW        2'h2
`define TAD_SZ_DS        2'h3
// Row numbers and cell geometry
`define TAD_ROW_LAST_DH  5'h16
`define TAD_ROW_STATUS   5'h18
`define TAD_CELL_BOTTOM  4'h9
`endif

// ---- sim/tad_attribute_decoder_bench.sv ----
`timescale 1ns/100ps
module tad_attribute_decoder_bench;
    localparam [4:0] VER = 5'h15;  // Arbitrary identity value
    // Bus
    logic mclk, rstn, psel, penable, pwrite, er, a, pix_shadow_src;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    // Stream and pixel inputs
    logic row_start, char_valid, flash_phase, sync_525, pix_valid, pix_fg, pix_odd, pix_box, pix_bg_black;
    logic [4:0] row_num;
    logic [7:0] char_code, page_attr_c5, c;
    logic [2:0] page_lang;
    logic [3:0] cell_line;
    // Outputs
    wire [31:0] prdata;
    wire pready, pslverr, cell_valid, cell_alt_table, cell_osd_symbol, cell_mosaic, cell_separated;
    wire cell_right_half, cell_box, line_skip, video_source_select_out, contrast_reduce_out_n, rgb_shown, dimmed;
    wire [7:0] cell_code;
    wire [2:0] cell_fg, cell_bg;
    wire [1:0] cell_size;
    wire [1:0] vc = {video_source_select_out, contrast_reduce_out_n};
    integer bad_count, n_tests, seed, i;

    tad_attribute_decoder #(.CHARSET_VERSION(VER)) i_dut (.*, .pix_osd_box(1'b0), .pix_text_area(1'b1));
    tad_tv_model i_tv (.*);

    // 50 ns clock
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask

    // One bus transfer; waits for pready
    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        integer k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do @(posedge mclk); while (pready !== 1'b1 && ++k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One character, cell sampled once registered
    task ch(input logic [7:0] cc);
        @(posedge mclk);
        char_valid <= 1'b1;
        char_code <= cc;
        @(posedge mclk);
        char_valid <= 1'b0;
        #1;
    endtask

    // Start of row
    task rs;
        @(posedge mclk);
        row_start <= 1'b1;
        @(posedge mclk);
        row_start <= 1'b0;
    endtask

    // One pixel
    task px(input logic f, input logic b, input logic k, input logic o);
        @(posedge mclk);
        pix_valid <= 1'b1;
        {pix_fg, pix_box, pix_bg_black, pix_odd} <= {f, b, k, o};
        @(posedge mclk);
        pix_valid <= 1'b0;
        #1;
    endtask

    // Reset value of register slot n
    function logic [31:0] rst_exp(input integer n);
        return (n < 2) ? 32'h0000_0001 : (n == 5) ? {27'h0, VER} : 32'h0;
    endfunction

    // OSD flag and code expected for a displayable code
    function logic [8:0] osd_exp(input logic [7:0] cc);
        return {(cc >= 8'h80 && cc <= 8'h9F), cc};
    endfunction

    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #2_000_000;
        bad_count++;
        print_verdict;
    end

    initial
    begin
        seed = 50;
        bad_count = 0;
        n_tests = 0;
        {rstn, psel, penable, pwrite, row_start, char_valid, flash_phase, sync_525} = '0;
        {pix_valid, pix_fg, pix_odd, pix_box, pix_bg_black, pix_shadow_src} = '0;
        {paddr, pwdata, char_code, page_attr_c5, cell_line} = '0;
        row_num = 5'h05;
        page_lang = 3'h5;
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        // Reset values, identity, refusal
        for (i = 0; i < 6; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, rst_exp(i));
        end
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd[4:0], VER);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 1'b1);
        // Bottom line dropped on 525 lines
        for (i = 0; i < 10; i++)
        begin
            @(posedge mclk);
            sync_525 <= 1'b1;
            cell_line <= 4'(i);
            @(posedge mclk);
            #1;
            chk(line_skip, i == 9);
        end
        $display("registers and lines done");
        // Colour codes
        rs;
        for (i = 0; i < 8; i++)
        begin
            ch(8'(i));
            chk({cell_valid, cell_code}, 9'h120);
            ch(8'h41);
            chk({cell_mosaic, cell_fg}, {1'b0, 3'(i)});
            ch(8'h10 + 8'(i));
            ch(8'h61);
            chk({cell_mosaic, cell_fg}, {1'b1, 3'(i)});
            ch(8'hB0 + 8'(i));
            chk({cell_code, cell_bg}, {8'h20, 3'(i)});
        end
        ch(8'h1D);
        chk(cell_bg, 3'h7);
        rs;
        ch(8'h03);
        ch(8'h41);
        rs;
        ch(8'h12);
        ch(8'h61);
        // Conceal and flash
        rs;
        ch(8'h18);
        ch(8'h41);
        chk(cell_code, 8'h20);
        ch(8'h02);
        ch(8'h41);
        chk(cell_code, 8'h41);
        flash_phase <= 1'b1;
        ch(8'h08);
        ch(8'h41);
        chk(cell_code, 8'h20);
        ch(8'h09);
        ch(8'h41);
        chk(cell_code, 8'h41);
        flash_phase <= 1'b0;
        // Hold graphics
        rs;
        ch(8'h11);
        ch(8'h1E);
        chk(cell_code, 8'h20);
        ch(8'h61);
        ch(8'h19);
        chk(cell_code, 8'h61);
        // Twist and boxes
        rs;
        ch(8'h1B);
        ch(8'h41);
        chk(cell_alt_table, 1'b1);
        ch(8'h0B);
        ch(8'h0B);
        ch(8'h41);
        chk(cell_box, 1'b1);
        ch(8'h0A);
        ch(8'h41);
        chk(cell_box, 1'b0);
        apb(1'b1, 8'h0C, 32'h0000_0500);
        rs;
        ch(8'h41);
        chk(cell_alt_table, 1'b1);
        ch(8'h1B);
        ch(8'h41);
        chk(cell_alt_table, 1'b0);
        apb(1'b1, 8'h0C, 32'h0000_0010);
        rs;
        ch(8'h41);
        chk(cell_alt_table, 1'b0);
        $display("serial attributes done");
        // Size codes and blanked row
        rs;
        ch(8'h0D);
        ch(8'h41);
        chk(cell_size, 2'h1);
        row_num <= 5'h06;
        rs;
        ch(8'h41);
        chk(cell_code, 8'h20);
        row_num <= 5'h17;
        rs;
        ch(8'h0D);
        ch(8'h41);
        chk(cell_size, 2'h0);
        rs;
        ch(8'h0E);
        ch(8'h41);
        ch(8'h42);
        chk(cell_right_half, 1'b1);
        row_num <= 5'h05;
        // Show_concealed_enable and random displayable codes
        apb(1'b1, 8'h10, 32'h0000_0001);
        rs;
        ch(8'h18);
        ch(8'h41);
        chk(cell_code, 8'h41);
        rs;
        for (i = 0; i < 24; i++)
        begin
            c = 8'h60 + 8'($random(seed) & 32'h3F);
            ch(c);
            chk({cell_osd_symbol, cell_code}, osd_exp(c));
        end
        $display("size and symbols done");
        // Display modes
        px(1'b1, 1'b0, 1'b0, 1'b0);
        chk(vc, 2'h1);
        apb(1'b1, 8'h00, 32'h0000_0046);
        px(1'b0, 1'b0, 1'b0, 1'b0);
        chk(vc, 2'h2);
        page_attr_c5 <= 8'h04;
        px(1'b0, 1'b0, 1'b0, 1'b0);
        chk(vc, 2'h1);
        page_attr_c5 <= 8'h00;
        apb(1'b1, 8'h00, 32'h0000_0031);
        apb(1'b1, 8'h08, 32'h0000_0000);
        px(1'b0, 1'b1, 1'b0, 1'b0);
        chk(video_source_select_out, 1'b0);
        apb(1'b1, 8'h08, 32'h0000_0002);
        px(1'b0, 1'b1, 1'b0, 1'b0);
        chk(video_source_select_out, 1'b1);
        apb(1'b1, 8'h0C, 32'h0000_0002);
        px(1'b0, 1'b1, 1'b1, 1'b0);
        chk(video_source_select_out, 1'b0);
        apb(1'b1, 8'h0C, 32'h0000_0008);
        px(1'b0, 1'b1, 1'b0, 1'b0);
        a = video_source_select_out;
        px(1'b0, 1'b1, 1'b0, 1'b1);
        chk(a ^ video_source_select_out, 1'b1);
        apb(1'b1, 8'h0C, 32'h0000_0009);
        pix_shadow_src <= 1'b1;
        px(1'b0, 1'b1, 1'b0, 1'b0);
        chk(video_source_select_out, 1'b1);
        $display("display modes done");
        print_verdict;
    end
endmodule // tad_attribute_decoder_bench

bind tad_attribute_decoder tad_checker #(.CHARSET_VERSION(CHARSET_VERSION)) i_chk (.*);

// ---- sim/tad_checker.sv ----
`timescale 1ns/100ps
// Port-level checks of the attribute decoder
module tad_checker #(
    parameter [4:0] CHARSET_VERSION = 5'h15  // Arbitrary identity value
) (
    // Clock and reset
    input logic        mclk,
    input logic        rstn,
    // Bus
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] prdata,
    input logic        pslverr,
    // Character stream and cells
    input logic        row_start,
    input logic [4:0]  row_num,
    input logic        char_valid,
    input logic [7:0]  char_code,
    input logic        cell_osd_symbol,
    input logic        cell_mosaic,
    input logic [2:0]  cell_fg,
    input logic [2:0]  cell_bg,
    input logic [1:0]  cell_size,
    // Line path
    input logic        sync_525,
    input logic [3:0]  cell_line,
    input logic        line_skip
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    AST_OSD_RANGE: assert property (char_valid && !row_start && char_code[7:5] == 3'h4 |=> cell_osd_symbol)
        else $error("osd symbol flag missing");
    AST_IDENT_READ: assert property (psel && !penable && !pwrite && paddr == 8'h14 |=> prdata[4:0] == CHARSET_VERSION && !pslverr)
        else $error("identity read wrong");
    AST_LINE_SKIP: assert property (##1 line_skip == ($past(sync_525) && $past(cell_line) == 4'h9))
        else $error("bottom line skip wrong");
    AST_BLACK_BG: assert property (char_valid && !row_start && char_code == 8'h1C |=> cell_bg == 3'h0)
        else $error("black background not set at");
    AST_UPPER_BG: assert property (char_valid && !row_start && char_code[7:3] == 5'h16 |=> cell_bg == $past(char_code[2:0]))
        else $error("upper background colour wrong");
    AST_ROW_DEFAULTS: assert property (row_start ##2 (char_valid && char_code == 8'h41) |=> cell_fg == 3'h7 && cell_bg == 3'h0 && !cell_mosaic)
        else $error("row defaults wrong");
    AST_NO_DH_LOW: assert property (row_start ##2 (char_valid && char_code == 8'h0D && row_num >= 5'h17) ##2 char_valid |=> cell_size == 2'h0)
        else $error("double height on bottom rows");
    AST_GFX_COLOUR: assert property (row_start ##2 (char_valid && char_code == 8'h12) ##2 (char_valid && char_code == 8'h61) |=> cell_mosaic && cell_fg == 3'h2)
        else $error("graphics colour wrong");
    AST_ALPHA_COLOUR: assert property (row_start ##2 (char_valid && char_code == 8'h03) ##2 char_valid |=> !cell_mosaic && cell_fg == 3'h3)
        else $error("alpha colour wrong");
endmodule // tad_checker

// ---- sim/tad_tv_model.sv ----
`timescale 1ns/100ps
// TV side: RGB switch and contrast stage
module tad_tv_model (
    // Clock
    input logic  mclk,
    // Switching inputs from the decoder
    input logic  video_source_select_out,
    input logic  contrast_reduce_out_n,
    // Picture state
    output logic      rgb_shown,
    output logic      dimmed
);
    // Switch to RGB when select is high, dim when reduce line is low
    always @(posedge mclk)
    begin
        rgb_shown <= video_source_select_out;
        dimmed <= !contrast_reduce_out_n;
    end
endmodule // tad_tv_model
